// ### logic/tone_pkg.sv
// constants shared by the buzzer tone generator files
package tone_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] IDX_TONE_OUTPUT_ENVELOPE_CTRL = 16'hFF6C;
  localparam logic [15:0] IDX_SINGLE_BURST_CTRL         = 16'hFF6D;
  localparam logic [15:0] IDX_TONE_FREQUENCY_SELECT     = 16'hFF6E;
  localparam logic [15:0] IDX_TONE_DUTY_SELECT          = 16'hFF6F;
  localparam int          ADDR_W                        = 18;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int BIT_OUTPUT_ENABLE   = 0;
  localparam int BIT_ENVELOPE_ACTIVE = 1;
  localparam int BIT_ENVELOPE_RESTART = 2;
  localparam int BIT_STEP_TIME_SEL   = 3;
  localparam int BIT_BURST_LENGTH    = 0;
  localparam int BIT_BURST_TRIGGER   = 1;
  localparam int BIT_BURST_STOP      = 2;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [2:0] RST_CODE = 3'h0;

  // ==========================================================
  // timing, in half oscillator cycles and 256 Hz ticks
  // ==========================================================
  localparam int OSC_HZ          = 32768;
  localparam int SLOT_HZ         = 256;
  localparam int HALF_PER_SLOT   = 2 * OSC_HZ / SLOT_HZ;
  localparam int SLOT_NS         = 1000000000 / SLOT_HZ;
  localparam int BURST_SHORT_NS  = 31250000;
  localparam int BURST_LONG_NS   = 125000000;
  localparam int STEP_SHORT_NS   = 62500000;
  localparam int STEP_LONG_NS    = 125000000;
  localparam logic [5:0] BURST_SHORT_SLOTS = 6'(BURST_SHORT_NS / SLOT_NS);
  localparam logic [5:0] BURST_LONG_SLOTS  = 6'(BURST_LONG_NS / SLOT_NS);
  localparam logic [5:0] STEP_SHORT_SLOTS  = 6'(STEP_SHORT_NS / SLOT_NS);
  localparam logic [5:0] STEP_LONG_SLOTS   = 6'(STEP_LONG_NS / SLOT_NS);
  localparam logic [2:0] LEVEL_MAX = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h7;

  // burst sequencer states
  typedef enum logic [1:0] {
    BURST_IDLE  = 2'b00,
    BURST_ARMED = 2'b01,
    BURST_RUN   = 2'b10,
    BURST_STOP  = 2'b11
  } burst_state_t;

endpackage : tone_pkg

// ### logic/tone_waveform.sv
// period counter producing the raw tone square wave
`timescale 1ns/1ps
module tone_waveform
  import tone_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       half_tick,
  input  wire logic [2:0] tone_frequency_code,
  input  wire logic [2:0] tone_duty_level,
  output logic            wave_active
);

  // period in half oscillator cycles: 16,20,24,28 then doubled
  function automatic logic [5:0] period_half(input logic [2:0] code);
    logic [5:0] base;
    base = 6'(16 + 4 * code[1:0]);
    period_half = code[2] ? 6'(base << 1) : base;
  endfunction : period_half

  // active half cycles: numerator scaled to the period
  function automatic logic [5:0] active_half(input logic [2:0] code,
                                             input logic [2:0] level);
    logic [4:0] num;
    num = code[1] ? 5'(12 - level) : 5'(8 - level);
    active_half = code[2] ? {num, 1'b0} : {1'b0, num};
  endfunction : active_half

  logic [5:0] phase_reg;
  logic [2:0] freq_reg;
  logic [2:0] duty_reg;

  // ==========================================================
  // period counter, selects latched only at the boundary
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= 6'h00;
      freq_reg  <= RST_CODE;
      duty_reg  <= RST_CODE;
    end
    else if (half_tick)
    begin
      if (phase_reg >= period_half(freq_reg) - 6'h01)
      begin
        phase_reg <= 6'h00;
        freq_reg  <= tone_frequency_code; // R23
        duty_reg  <= tone_duty_level;     // R23
      end
      else
        phase_reg <= phase_reg + 6'h01;  // R22
    end
  end

  // active phase sits at the start of each period
  assign wave_active = phase_reg < active_half(freq_reg, duty_reg); // R4

endmodule : tone_waveform

// ### logic/burst_sequencer.sv
// one-shot burst timing aligned to the 256 Hz slot tick
`timescale 1ns/1ps
module burst_sequencer
  import tone_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slot_tick,
  input  wire logic trigger,
  input  wire logic stop,
  input  wire logic tone_output_enable,
  input  wire logic burst_length_select,
  output logic      burst_busy,
  output logic      burst_sounding
);

  burst_state_t state_reg;
  logic [5:0]   left_reg;
  logic         retrig_reg;
  logic         go;
  logic [5:0]   length;

  // continuous output blocks new triggers
  assign go     = trigger && !tone_output_enable; // R13
  assign length = burst_length_select ? BURST_LONG_SLOTS
                                      : BURST_SHORT_SLOTS; // R11

  // ==========================================================
  // state machine: start and end only on slot ticks
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg  <= BURST_IDLE; // R17
      left_reg   <= 6'h00;
      retrig_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        BURST_IDLE:
          if (go)
            state_reg <= BURST_ARMED; // R12
        BURST_ARMED:
          if (stop && !go)
            state_reg <= BURST_IDLE; // R16
          else if (slot_tick)
          begin
            state_reg  <= BURST_RUN;  // R21
            left_reg   <= length;
            retrig_reg <= 1'b0;
          end
        BURST_RUN:
        begin
          // a retrigger reloads the length at the next slot tick
          if (go)
            retrig_reg <= 1'b1; // R14
          if (stop && !go)
            state_reg <= BURST_STOP; // R16
          else if (slot_tick)
          begin
            if (retrig_reg || go)
            begin
              left_reg   <= length; // R14
              retrig_reg <= 1'b0;
            end
            else if (left_reg <= 6'h01)
              state_reg <= BURST_IDLE; // R12 R21
            else
              left_reg <= left_reg - 6'h01;
          end
        end
        BURST_STOP:
          if (go)
          begin
            state_reg  <= BURST_RUN; // R14
            retrig_reg <= 1'b1;
          end
          else if (slot_tick)
            state_reg <= BURST_IDLE; // R21
        default:
          state_reg <= BURST_IDLE;
      endcase
    end
  end

  assign burst_busy     = state_reg != BURST_IDLE;  // R15
  assign burst_sounding = state_reg == BURST_RUN ||
                          state_reg == BURST_STOP;

endmodule : burst_sequencer

// ### logic/buzzer_tone_generator.sv
// buzzer tone generator top: apb registers, envelope and pin drive
// Functional notes
// (R1) Output enable set drives the tone waveform onto the pin continuously.
// (R2) Output enable clear holds the pin at its inactive high level; the code still drives the tone onto the pin while a burst sounds.
// (R3) Three-bit frequency code selects one of eight tone frequencies.
// (R4) Duty level sets active fraction; numerators 8..1 or 12..5.
// (R5) With envelope on, the envelope sequencer overrides the duty level; the code does so only while output enable is set, not during a burst.
// (R6) Writing one to envelope restart returns duty to level one.
// (R7) Restart ignored if envelope off and no tone; zero does nothing.
// (R8) Write-only bits and unused bits read back as zero.
// (R9) Envelope enable applies the decaying duty envelope during output.
// (R10) Step time select gives 125 or 62.5 ms per level, seven steps.
// (R11) Burst length select gives 125 or 31.25 ms bursts only.
// (R12) Writing one to trigger starts a self-ending burst; zero does nothing.
// (R13) Triggers are accepted only while output enable is zero.
// (R14) A trigger during a burst restarts its length timing.
// (R15) Trigger bit reads one while busy, zero when ready.
// (R16) Stop ends an active burst early; otherwise stop writes do nothing.
// (R17) Reset clears all control fields and burst status.
// (R18) Waveform runs free of the enable, so gating may glitch.
// (R19) All timing is divided from the low-speed oscillator input.
// (R20) Envelope starts at level one, steps to level eight, then holds.
// (R21) Burst start and end align to an internal 256 Hz tick.
// (R22) Period counter reloads at 8..28 oscillator cycles in half units.
// (R23) Frequency and duty writes take effect at the period boundary.
`timescale 1ns/1ps
module buzzer_tone_generator
  import tone_pkg::*;
#(
  parameter bit ACTIVE_LOW = 1'b1
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              low_speed_oscillator,
  output logic                   tone_output_pin
);

  // ==========================================================
  // register state
  // ==========================================================
  logic       tone_output_enable_reg;
  logic       envelope_active_reg;
  logic       envelope_step_time_select_reg;
  logic       burst_length_select_reg;
  logic [2:0] tone_frequency_code_reg;
  logic [2:0] tone_duty_level_reg;
  logic [2:0] env_level_reg;
  logic [5:0] step_cnt_reg;
  logic       osc_prev_reg;
  logic [7:0] slot_cnt_reg;
  logic       slot_tick_reg;
  logic [31:0] prdata_reg;
  logic       pready_reg;
  logic       pslverr_reg;
  logic       pin_reg;

  logic       half_tick;
  logic       wave_active;
  logic       burst_busy;
  logic       burst_sounding;
  logic       wr_access;
  logic       sounding;
  logic       hit;
  logic [2:0] reg_sel;
  logic [2:0] duty_applied;
  logic       restart_req;
  logic       trigger_req;
  logic       stop_req;
  logic [3:0] read_value;
  logic [5:0] step_len;

  // map a byte address onto a register number, 4 when unmapped
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = a[ADDR_W-1:2];
    if (a[1:0] != 2'b00)
      decode = 3'h4;
    else if (idx == IDX_TONE_OUTPUT_ENVELOPE_CTRL)
      decode = 3'h0;
    else if (idx == IDX_SINGLE_BURST_CTRL)
      decode = 3'h1;
    else if (idx == IDX_TONE_FREQUENCY_SELECT)
      decode = 3'h2;
    else if (idx == IDX_TONE_DUTY_SELECT)
      decode = 3'h3;
    else
      decode = 3'h4;
  endfunction : decode

  // ==========================================================
  // apb slave: no wait states, answer registered from setup
  // ==========================================================
  assign reg_sel   = decode(paddr);
  assign hit       = reg_sel != 3'h4;
  assign wr_access = psel && penable && pready_reg && pwrite && hit;

  // reads show live state; write-only and unused bits are zero
  always_comb
  begin
    case (reg_sel)
      3'h0: read_value = {envelope_step_time_select_reg, 1'b0,
                          envelope_active_reg,
                          tone_output_enable_reg}; // R8
      3'h1: read_value = {2'b00, burst_busy,
                          burst_length_select_reg}; // R8 R15
      3'h2: read_value = {1'b0, tone_frequency_code_reg};
      3'h3: read_value = {1'b0, tone_duty_level_reg};
      default: read_value = 4'h0;
    endcase
  end

  // answer flops; pready rises in the access cycle of each transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg       <= 1'b0;
      pslverr_reg      <= 1'b0;
      prdata_reg       <= 32'h0000_0000;
    end
    else
    begin
      pready_reg       <= psel && !penable;
      pslverr_reg      <= psel && !penable && !hit;
      if (psel && !penable && !pwrite)
        prdata_reg <= {28'h000_0000, read_value};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================
  // control registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tone_output_enable_reg        <= RST_CTRL[0]; // R17
      envelope_active_reg           <= RST_CTRL[0];
      envelope_step_time_select_reg <= RST_CTRL[0];
      burst_length_select_reg       <= RST_CTRL[0];
      tone_frequency_code_reg       <= RST_CODE;
      tone_duty_level_reg           <= RST_CODE;
    end
    else if (wr_access)
    begin
      case (reg_sel)
        3'h0:
        begin
          tone_output_enable_reg        <= pwdata[BIT_OUTPUT_ENABLE];
          envelope_active_reg           <= pwdata[BIT_ENVELOPE_ACTIVE];
          envelope_step_time_select_reg <= pwdata[BIT_STEP_TIME_SEL];
        end
        3'h1: burst_length_select_reg <= pwdata[BIT_BURST_LENGTH];
        3'h2: tone_frequency_code_reg <= pwdata[2:0]; // R3
        3'h3: tone_duty_level_reg     <= pwdata[2:0];
        default: tone_duty_level_reg  <= tone_duty_level_reg;
      endcase
    end
  end

  // command strobes from write-only bits; writing zero does nothing
  assign restart_req = wr_access && reg_sel == 3'h0 &&
                       pwdata[BIT_ENVELOPE_RESTART]; // R6
  assign trigger_req = wr_access && reg_sel == 3'h1 &&
                       pwdata[BIT_BURST_TRIGGER];    // R12
  assign stop_req    = wr_access && reg_sel == 3'h1 &&
                       pwdata[BIT_BURST_STOP];       // R16

  // ==========================================================
  // oscillator edges and 256 Hz slot tick
  // ==========================================================
  // both oscillator edges count, giving half-cycle duty resolution
  assign half_tick = low_speed_oscillator ^ osc_prev_reg; // R19

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_prev_reg  <= 1'b0;
      slot_cnt_reg  <= 8'h00;
      slot_tick_reg <= 1'b0;
    end
    else
    begin
      osc_prev_reg  <= low_speed_oscillator;
      slot_tick_reg <= 1'b0;
      if (half_tick)
      begin
        if (slot_cnt_reg == 8'(HALF_PER_SLOT - 1))
        begin
          slot_cnt_reg  <= 8'h00;
          slot_tick_reg <= 1'b1; // R19 R21
        end
        else
          slot_cnt_reg <= slot_cnt_reg + 8'h01;
      end
    end
  end

  // ==========================================================
  // digital envelope
  // ==========================================================
  assign step_len = envelope_step_time_select_reg ? STEP_LONG_SLOTS
                                                  : STEP_SHORT_SLOTS; // R10

  // level one on output start or accepted restart, then decay and hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      env_level_reg <= LEVEL_MAX;
      step_cnt_reg  <= 6'h00;
    end
    else if (!tone_output_enable_reg ||
             (restart_req &&
              (envelope_active_reg || sounding))) // R6 R7 R20
    begin
      env_level_reg <= LEVEL_MAX;
      step_cnt_reg  <= 6'h00;
    end
    else if (envelope_active_reg && slot_tick_reg)
    begin
      if (step_cnt_reg >= step_len - 6'h01)
      begin
        step_cnt_reg <= 6'h00;
        if (env_level_reg != LEVEL_MIN)
          env_level_reg <= env_level_reg + 3'h1; // R9 R20
      end
      else
        step_cnt_reg <= step_cnt_reg + 6'h01;
    end
  end

  // the burst never carries an envelope
  assign duty_applied = (envelope_active_reg && tone_output_enable_reg)
                        ? env_level_reg : tone_duty_level_reg; // R5 R9

  // ==========================================================
  // tone waveform and burst sequencer
  // ==========================================================
  tone_waveform u_wave (
    .pclk                (pclk),
    .presetn             (presetn),
    .half_tick           (half_tick),
    .tone_frequency_code (tone_frequency_code_reg),
    .tone_duty_level     (duty_applied),
    .wave_active         (wave_active)
  );

  burst_sequencer u_burst (
    .pclk                (pclk),
    .presetn             (presetn),
    .slot_tick           (slot_tick_reg),
    .trigger             (trigger_req),
    .stop                (stop_req),
    .tone_output_enable  (tone_output_enable_reg),
    .burst_length_select (burst_length_select_reg),
    .burst_busy          (burst_busy),
    .burst_sounding      (burst_sounding)
  );

  assign sounding = tone_output_enable_reg || burst_sounding;

  // ==========================================================
  // pin drive
  // ==========================================================
  // the waveform free-runs, so gating can cut a period short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_reg <= ACTIVE_LOW; // R2
    else if (sounding)
      pin_reg <= wave_active ^ ACTIVE_LOW; // R1 R18
    else
      pin_reg <= ACTIVE_LOW; // R2
  end

  assign tone_output_pin = pin_reg;

endmodule : buzzer_tone_generator

// ### test/piezo_stage_model.sv
// behavioural transistor stage and piezo hanging on the tone pin
`timescale 1ns/1ps
module piezo_stage_model
#(
  parameter bit ACTIVE_LOW = 1'b1
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic drive_pin,
  output logic      sounding,
  output int        sound_cycles
);
  // ==========
  // drive stage
  // ==========
  // the transistor conducts only while the pin sits at its active level
  assign sounding = (drive_pin != ACTIVE_LOW);

  // drive time stands in for the energy handed to the piezo
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sound_cycles <= 0;
    else if (sounding)
      sound_cycles <= sound_cycles + 1;
  end
endmodule : piezo_stage_model

// ### test/buzzer_tone_generator_properties.sv
// port checker for the buzzer tone generator, bound to its top
`timescale 1ns/1ps
module buzzer_tone_generator_properties
  import tone_pkg::*;
#(
  parameter bit ACTIVE_LOW = 1'b1
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              low_speed_oscillator,
  input wire logic              tone_output_pin
);
  // ==========
  // helper state
  // ==========
  localparam logic [ADDR_W-1:0] CTRL_A  = {IDX_TONE_OUTPUT_ENVELOPE_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] BURST_A = {IDX_SINGLE_BURST_CTRL, 2'b00};
  logic en_seen;
  logic trig_seen;
  wire  wr_done = psel && penable && pready && pwrite;

  // shadow of the enable bit as software last wrote it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_seen <= 1'b0;
    else if (wr_done && paddr == CTRL_A)
      en_seen <= pwdata[0];
  end

  // sticky: we cannot see when a burst ends, so stay lenient after one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_seen <= 1'b0;
    else if (wr_done && paddr == BURST_A && pwdata[1] && !en_seen)
      trig_seen <= 1'b1;
  end

  // ==========
  // properties
  // ==========
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  chk_ready_after_setup:
    assert property (setup_s |=> access_s)
    else $error("no answer after setup");
  chk_ready_only_access:
    assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("pready outside access");
  chk_err_with_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_misaligned:
    assert property (access_s and paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
  chk_idle_data_zero:
    assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_upper_bits_zero:
    assert property (pready |-> prdata[31:4] == 28'h0)
    else $error("unused read bits set");
  chk_restart_reads_zero:
    assert property (access_s and !pwrite && paddr == CTRL_A |-> !prdata[2])
    else $error("restart bit reads one");
  chk_stop_reads_zero:
    assert property (access_s and !pwrite && paddr == BURST_A
                     |-> prdata[3:2] == 2'b00)
    else $error("stop or unused bit reads one");
  chk_pin_idle_high:
    assert property (tone_output_pin != ACTIVE_LOW
                     |-> en_seen || $past(en_seen) || $past(en_seen, 2)
                         || trig_seen)
    else $error("pin active while output is off");
  chk_pin_reset_idle:
    assert property ($rose(presetn) |-> tone_output_pin == ACTIVE_LOW)
    else $error("pin active after reset");
endmodule : buzzer_tone_generator_properties

bind buzzer_tone_generator buzzer_tone_generator_properties
  #(.ACTIVE_LOW(ACTIVE_LOW)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .low_speed_oscillator(low_speed_oscillator),
  .tone_output_pin(tone_output_pin));

// ### test/buzzer_tone_generator_bench.sv
// self-checking bench for the buzzer tone generator
`timescale 1ns/1ps
module buzzer_tone_generator_bench;
  import tone_pkg::*;
  // ==========
  // signals
  // ==========
  localparam int SLOT = 512; // 256 half ticks at one half tick per 2 cycles
  localparam logic [ADDR_W-1:0] A_CTRL  = {IDX_TONE_OUTPUT_ENVELOPE_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_BURST = {IDX_SINGLE_BURST_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_FREQ  = {IDX_TONE_FREQUENCY_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] A_DUTY  = {IDX_TONE_DUTY_SELECT, 2'b00};
  logic              pclk = 1'b0;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              osc = 1'b0;
  logic              tone_output_pin;
  logic              sounding;
  int                sound_cycles;
  int                failures;
  int                total_checks;
  int                seed;
  int                cyc = 0;
  int                i;
  int                t0;
  int                s0;
  int                dur;
  int                slots;
  logic [31:0]       rd;
  logic              err;
  logic [ADDR_W-1:0] regs[4] = '{A_CTRL, A_BURST, A_FREQ, A_DUTY};
  int                per_tab[$] = '{16, 20, 24, 28, 32, 40, 48, 56};

  buzzer_tone_generator #(.ACTIVE_LOW(1'b1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_oscillator(osc),
    .tone_output_pin(tone_output_pin));
  piezo_stage_model #(.ACTIVE_LOW(1'b1)) stage (
    .pclk(pclk), .presetn(presetn), .drive_pin(tone_output_pin),
    .sounding(sounding), .sound_cycles(sound_cycles));

  // clock; the oscillator is sped up so long counts stay affordable
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1)
      osc <= ~osc;
  end

  // ==========
  // tasks
  // ==========
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      check(32'h0, 32'h1);
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task measure(output int lo, output int per);
    int n;
    n = 0;
    while (tone_output_pin !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    while (tone_output_pin !== 1'b0 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    lo = 0;
    while (tone_output_pin === 1'b0 && lo < 400)
    begin
      @(posedge pclk);
      lo++;
    end
    per = lo;
    while (tone_output_pin === 1'b1 && per < 400)
    begin
      @(posedge pclk);
      per++;
    end
  endtask : measure

  // model: period and active half ticks; the second period is judged
  task expect_tone(input int c, input int l);
    int lo;
    int per;
    int act;
    act = ((c & 2) ? 12 : 8) - l;
    if (c & 4)
      act = act * 2;
    measure(lo, per);
    measure(lo, per);
    check(lo, 2 * act);
    check(per, 2 * per_tab[c]);
  endtask : expect_tone

  task burst_len(input int t, output int d);
    do
      apb(1'b0, A_BURST, 32'h0);
    while (rd[1] === 1'b1 && cyc - t < 40000);
    if (rd[1] !== 1'b0)
    begin
      check(rd, 32'h0);
      results();
    end
    d = cyc - t;
  endtask : burst_len

  // ==========
  // main sequence
  // ==========
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h0;
    {failures, total_checks} = 64'h0;
    seed = 47771;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    check(tone_output_pin, 1'b1);
    apb(1'b0, 18'h3FDB2, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, A_FREQ, 32'hFFFFFFFF);
    apb(1'b0, A_FREQ, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, A_DUTY, 32'hFFFFFFFD);
    apb(1'b0, A_DUTY, 32'h0);
    check(rd, 32'h5);
    apb(1'b1, A_CTRL, 32'hC);
    apb(1'b0, A_CTRL, 32'h0);
    check(rd, 32'h8);
    // every frequency code with a random duty level, output on
    apb(1'b1, A_CTRL, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      slots = $random(seed) & 7;
      apb(1'b1, A_FREQ, i);
      apb(1'b1, A_DUTY, slots);
      expect_tone(i, slots);
    end
    apb(1'b1, A_BURST, 32'h2);
    apb(1'b0, A_BURST, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    s0 = sound_cycles;
    repeat (300) @(posedge pclk);
    check(sound_cycles - s0, 0);
    // bursts of both lengths, each must end by itself on a slot tick
    apb(1'b1, A_DUTY, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, A_BURST, i);
      t0 = cyc;
      s0 = sound_cycles;
      apb(1'b1, A_BURST, 2 | i);
      apb(1'b0, A_BURST, 32'h0);
      check(rd, 2 | i);
      burst_len(t0, dur);
      slots = i ? 32 : 8;
      check(dur >= slots * SLOT && dur <= (slots + 1) * SLOT + 40, 1);
      check(sound_cycles > s0 && sound_cycles - s0 <= slots * SLOT, 1);
    end
    // early stop, then a retrigger that stretches the burst
    apb(1'b1, A_BURST, 32'h2);
    repeat (2 * SLOT) @(posedge pclk);
    t0 = cyc;
    apb(1'b1, A_BURST, 32'h4);
    burst_len(t0, dur);
    check(dur <= SLOT + 40, 1);
    t0 = cyc;
    apb(1'b1, A_BURST, 32'h2);
    repeat (3 * SLOT) @(posedge pclk);
    apb(1'b1, A_BURST, 32'h2);
    burst_len(t0, dur);
    check(dur >= 11 * SLOT, 1);
    // envelope overrides the quietest duty level and decays
    apb(1'b1, A_DUTY, 32'h7);
    apb(1'b1, A_CTRL, 32'h3);
    expect_tone(7, 0);
    repeat (18 * SLOT) @(posedge pclk);
    expect_tone(7, 1);
    apb(1'b1, A_CTRL, 32'h7);
    expect_tone(7, 0);
    apb(1'b1, A_CTRL, 32'h1);
    expect_tone(7, 7);
    results();
  end
endmodule : buzzer_tone_generator_bench
